// File: lsa_pkg.sv
package lsa_pkg;
  // bank select lives in the top two bits of the link control byte
  localparam int BANK_SEL_MSB = 7;
  localparam int BANK_SEL_LSB = 6;
  localparam logic [1:0] BANK_0 = 2'h0;
  localparam logic [1:0] BANK_1 = 2'h1;
  localparam logic [1:0] BANK_2 = 2'h2;
  localparam logic [1:0] BANK_3 = 2'h3;

  // offsets common to all banks
  localparam logic [2:0] OFS_LINK_CTRL = 3'h3;
  // bank 0
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_MODE_CTRL = 3'h4;
  localparam logic [2:0] OFS_LINK_STATUS = 3'h5;
  localparam logic [2:0] OFS_SCRATCH_AUX = 3'h7;
  // bank 1 (divisor only) and bank 2
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_EXT_CTRL1 = 3'h2;
  localparam logic [2:0] OFS_EXT_CTRL2 = 3'h4;
  localparam logic [2:0] OFS_TX_LEVEL = 3'h6;
  localparam logic [2:0] OFS_RX_LEVEL = 3'h7;
  // bank 3
  localparam logic [2:0] OFS_IR_CTRL1 = 3'h0;
  localparam logic [2:0] OFS_IR_CTRL2 = 3'h1;

  // operating mode codes
  localparam logic [2:0] MODE_UART = 3'h0;
  localparam logic [2:0] MODE_MEDIUM_IR = 3'h4;
  localparam logic [2:0] MODE_FAST_IR = 3'h5;
  localparam logic [2:0] MODE_CONSUMER_REMOTE = 3'h6;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;

  // field positions
  localparam int EXT1_EXTENDED_SELECT = 0;
  localparam int EXT1_LOOP = 4;
  localparam int EXT2_LOCK = 7;
  localparam int MCR_INT_ENABLE = 3;
  localparam int MCR_LOOP = 4;
  localparam int IR2_FRAME_END_METHOD = 0;
  localparam int IR2_FRAME_END_STOP = 1;
  localparam int AUX_RX_TIMEOUT = 0;
  localparam int AUX_EOF_IN_FIFO = 1;
  localparam int AUX_SET_EOT = 2;
  localparam int AUX_TX_HALT_FEND = 3;
  localparam int AUX_LOST_ACTIVITY = 4;
  localparam int AUX_BUSY_ACTIVE = 5;
  localparam int AUX_TX_UNDERRUN = 6;
  localparam int AUX_CLEAR_TIMER = 7;

  // masks
  localparam logic [7:0] MCR_EXT_WRITE_MASK = 8'hfc;
  localparam logic [7:0] FALLBACK_MCR_CLEAR = 8'hfc;
  localparam logic [7:0] FALLBACK_EXT1_CLEAR = 8'ha0;
  localparam logic [7:0] FALLBACK_EXT2_CLEAR = 8'h3f;
  localparam logic [7:0] FALLBACK_IR1_CLEAR = 8'h0c;
  localparam logic [7:0] EXT1_WRITE_MASK = 8'hbf;
  localparam logic [7:0] EXT2_WRITE_MASK = 8'hbf;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;
  localparam logic RESET_TX_READY = 1'b1;
  localparam logic RESET_TX_EMPTY = 1'b1;

  typedef struct packed {
    logic [7:0] rdData;
    logic [15:0] divisor;
    logic [7:0] linkCtrl;
    logic [7:0] modeCtrl;
    logic [2:0] mode;
    logic [7:0] ext1;
    logic [7:0] ext2;
    logic [7:0] ir1;
    logic [7:0] ir2;
    logic [7:0] scratch;
    logic rxTimeout;
    logic setEot;
    logic txHaltFend;
    logic rxActivity;
    logic rxSampling;
    logic txUnderrun;
    logic frameTooLong;
    logic frameEnd;
    logic txReady;
    logic txEmpty;
    logic txPush;
    logic [7:0] txData;
    logic rxPop;
    logic statusRead;
    logic clearTimer;
    logic txSoftRst;
    logic rxSoftRst;
    logic txHalted;
  } lsa_state_t;
endpackage

// File: lsa_link_status_aux.sv
`timescale 1ns/1ps
module lsa_link_status_aux
  import lsa_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // transmit path
  input wire logic txHoldEmpty,
  input wire logic txFrontIdle,
  input wire logic txUnderrunEvt,
  input wire logic txFrameCountZero,
  output logic txFifoPush,
  output logic [7:0] txFifoData,
  output logic setEndOfTransmit,
  output logic txHalted,
  // receive path
  input wire logic [7:0] rxFifoData,
  input wire logic [4:0] rxLowStatus,
  input wire logic fifoEnabled,
  input wire logic errCharInFifo,
  input wire logic frameTooLongEvt,
  input wire logic frameEndEvt,
  input wire logic rxTimeoutEvt,
  input wire logic eofInFifo,
  input wire logic lostFrameBottom,
  input wire logic rxFrameBusy,
  input wire logic irPulseEvt,
  output logic rxFifoPop,
  output logic rxSamplingActive,
  output logic statusReadPulse,
  // fifo levels
  input wire logic [7:0] txFifoLevel,
  input wire logic [7:0] rxFifoLevel,
  // soft resets and timer
  input wire logic txSoftResetReq,
  input wire logic rxSoftResetReq,
  output logic txSoftReset,
  output logic rxSoftReset,
  output logic clearTimerEvent,
  // configuration
  output logic [15:0] divisorValue,
  output logic [2:0] operatingMode,
  output logic extendedMode,
  output logic [7:0] modeControl,
  output logic [7:0] extCtrl1,
  output logic [7:0] extCtrl2,
  output logic [7:0] irCtrl1,
  output logic [7:0] irCtrl2
);

  function automatic logic isFastIr(input logic [2:0] m);
    return (m == MODE_MEDIUM_IR) || (m == MODE_FAST_IR);
  endfunction

  function automatic logic isRemote(input logic [2:0] m);
    return m == MODE_CONSUMER_REMOTE;
  endfunction

  lsa_state_t s_q;
  lsa_state_t s_d;

  logic ext;
  logic fastIr;
  logic remote;
  logic [1:0] bank;
  logic wrAux;
  logic legacyAcc;
  logic modeChange;
  logic txSr;
  logic rxSr;
  logic [7:0] lsrByte;
  logic [7:0] auxByte;

  always_comb begin
    s_d = s_q;
    s_d.txPush = 1'b0;
    s_d.rxPop = 1'b0;
    s_d.statusRead = 1'b0;
    s_d.clearTimer = 1'b0;
    s_d.rdData = RESET_BYTE;
    ext = s_q.ext1[EXT1_EXTENDED_SELECT];
    fastIr = isFastIr(s_q.mode);
    remote = isRemote(s_q.mode);
    bank = s_q.linkCtrl[BANK_SEL_MSB:BANK_SEL_LSB];
    wrAux = 1'b0;
    legacyAcc = (regWrEn || regRdEn) && bank == BANK_1 &&
                (regAddr == OFS_DIV_LOW || regAddr == OFS_DIV_HIGH);

    lsrByte = {fastIr ? s_q.frameEnd : (fifoEnabled & errCharInFifo),
               s_q.txEmpty, s_q.txReady,
               fastIr ? s_q.frameTooLong : rxLowStatus[4],
               rxLowStatus[3:0]};
    auxByte = {1'b0, s_q.txUnderrun,
               fastIr ? rxFrameBusy : s_q.rxSampling,
               fastIr ? lostFrameBottom : s_q.rxActivity,
               s_q.txHaltFend, s_q.setEot,
               fastIr & eofInFifo,
               s_q.rxTimeout};

    // reads: data stands one cycle after the strobe
    if (regRdEn) begin
      unique case (bank)
        BANK_0: begin
          unique case (regAddr)
            OFS_DATA: begin
              s_d.rdData = rxFifoData;
              s_d.rxPop = 1'b1;
            end
            OFS_MODE_CTRL: begin
              s_d.rdData = ext ? (s_q.modeCtrl & MCR_EXT_WRITE_MASK)
                               : {3'h0, s_q.ext1[EXT1_LOOP], s_q.modeCtrl[MCR_INT_ENABLE], 3'h0};
            end
            OFS_LINK_STATUS: begin
              s_d.rdData = lsrByte;
              s_d.statusRead = 1'b1;
            end
            OFS_SCRATCH_AUX: s_d.rdData = ext ? auxByte : s_q.scratch;
            OFS_LINK_CTRL: s_d.rdData = s_q.linkCtrl;
            default: s_d.rdData = RESET_BYTE;
          endcase
        end
        BANK_1: begin
          unique case (regAddr)
            OFS_DIV_LOW: s_d.rdData = s_q.divisor[7:0];
            OFS_DIV_HIGH: s_d.rdData = s_q.divisor[15:8];
            OFS_LINK_CTRL: s_d.rdData = s_q.linkCtrl;
            default: s_d.rdData = RESET_BYTE;
          endcase
        end
        BANK_2: begin
          unique case (regAddr)
            OFS_DIV_LOW: s_d.rdData = s_q.divisor[7:0];
            OFS_DIV_HIGH: s_d.rdData = s_q.divisor[15:8];
            OFS_EXT_CTRL1: s_d.rdData = s_q.ext1;
            OFS_LINK_CTRL: s_d.rdData = s_q.linkCtrl;
            OFS_EXT_CTRL2: s_d.rdData = s_q.ext2;
            OFS_TX_LEVEL: s_d.rdData = txFifoLevel;
            OFS_RX_LEVEL: s_d.rdData = rxFifoLevel;
            default: s_d.rdData = RESET_BYTE;
          endcase
        end
        BANK_3: begin
          unique case (regAddr)
            OFS_IR_CTRL1: s_d.rdData = s_q.ir1;
            OFS_IR_CTRL2: s_d.rdData = s_q.ir2;
            OFS_LINK_CTRL: s_d.rdData = s_q.linkCtrl;
            default: s_d.rdData = RESET_BYTE;
          endcase
        end
      endcase
    end

    // writes
    if (regWrEn) begin
      if (regAddr == OFS_LINK_CTRL) begin
        s_d.linkCtrl = regWrData;
      end else begin
        unique case (bank)
          BANK_0: begin
            if (regAddr == OFS_DATA) begin
              s_d.txPush = 1'b1;
              s_d.txData = regWrData;
            end else if (regAddr == OFS_MODE_CTRL) begin
              if (ext) begin
                s_d.modeCtrl = regWrData & MCR_EXT_WRITE_MASK;
              end else begin
                s_d.modeCtrl[MCR_INT_ENABLE] = regWrData[MCR_INT_ENABLE];
                s_d.ext1[EXT1_LOOP] = regWrData[MCR_LOOP];
              end
            end else if (regAddr == OFS_SCRATCH_AUX) begin
              if (ext) begin
                wrAux = 1'b1;
              end else begin
                s_d.scratch = regWrData;
              end
            end
          end
          BANK_1: begin
            // locked non-extended access leaves the divisor alone
            if (ext || !s_q.ext2[EXT2_LOCK]) begin
              if (regAddr == OFS_DIV_LOW) s_d.divisor[7:0] = regWrData;
              if (regAddr == OFS_DIV_HIGH) s_d.divisor[15:8] = regWrData;
            end
          end
          BANK_2: begin
            if (regAddr == OFS_DIV_LOW) s_d.divisor[7:0] = regWrData;
            if (regAddr == OFS_DIV_HIGH) s_d.divisor[15:8] = regWrData;
            if (regAddr == OFS_EXT_CTRL1) s_d.ext1 = regWrData & EXT1_WRITE_MASK;
            if (regAddr == OFS_EXT_CTRL2) s_d.ext2 = regWrData & EXT2_WRITE_MASK;
          end
          BANK_3: begin
            if (regAddr == OFS_IR_CTRL1) s_d.ir1 = regWrData;
            if (regAddr == OFS_IR_CTRL2) s_d.ir2 = regWrData;
          end
        endcase
      end
    end

    // legacy divisor fallback
    if (legacyAcc) begin
      if (ext) begin
        s_d.ext1[EXT1_EXTENDED_SELECT] = 1'b0;
        s_d.modeCtrl = s_d.modeCtrl & ~FALLBACK_MCR_CLEAR;
        s_d.ext1 = s_d.ext1 & ~FALLBACK_EXT1_CLEAR;
        s_d.ext2 = s_d.ext2 & ~FALLBACK_EXT2_CLEAR;
        s_d.ir1 = s_d.ir1 & ~FALLBACK_IR1_CLEAR;
      end else if (!s_q.ext2[EXT2_LOCK]) begin
        s_d.ext1 = s_d.ext1 & ~FALLBACK_EXT1_CLEAR;
        s_d.ext2 = s_d.ext2 & ~FALLBACK_EXT2_CLEAR;
      end
    end

    // outside extended mode the line runs as a plain uart
    s_d.mode = s_d.ext1[EXT1_EXTENDED_SELECT] ? s_d.modeCtrl[MODE_MSB:MODE_LSB] : MODE_UART;
    modeChange = s_d.mode != s_q.mode;
    txSr = txSoftResetReq | modeChange;
    rxSr = rxSoftResetReq | modeChange;
    s_d.txSoftRst = txSr;
    s_d.rxSoftRst = rxSr;

    // transmit status follows the holding stage, a push drops ready at once;
    // the far side shows a pushed byte one cycle late, so the byte in flight keeps ready low
    s_d.txReady = txHoldEmpty & ~s_d.txPush & ~s_q.txPush;
    s_d.txEmpty = txHoldEmpty & txFrontIdle & ~s_d.txPush & ~s_q.txPush;

    // link status sticky flags: set wins over the read clear
    if (s_d.statusRead) s_d.frameTooLong = 1'b0;
    if (s_d.statusRead) s_d.frameEnd = 1'b0;
    if (fastIr && frameTooLongEvt) s_d.frameTooLong = 1'b1;
    if (fastIr && frameEndEvt) s_d.frameEnd = 1'b1;

    // auxiliary bits; software clears lose to a hardware set in the same cycle
    if (s_d.rxPop) s_d.rxTimeout = 1'b0;
    if (rxTimeoutEvt) s_d.rxTimeout = 1'b1;
    if (s_d.txPush) s_d.setEot = 1'b0;
    if (wrAux && regWrData[AUX_SET_EOT] && (fastIr || remote)) s_d.setEot = 1'b1;
    if (wrAux && regWrData[AUX_TX_HALT_FEND]) s_d.txHaltFend = 1'b0;
    if (fastIr && s_q.ir2[IR2_FRAME_END_STOP] && txFrameCountZero)
      s_d.txHaltFend = 1'b1;
    if (regRdEn && bank == BANK_0 && regAddr == OFS_SCRATCH_AUX && ext)
      s_d.rxActivity = 1'b0;
    if (remote && irPulseEvt) s_d.rxActivity = 1'b1;
    if (wrAux && regWrData[AUX_BUSY_ACTIVE]) s_d.rxSampling = 1'b0;
    if (remote && irPulseEvt) s_d.rxSampling = 1'b1;
    if (wrAux && regWrData[AUX_TX_UNDERRUN]) s_d.txUnderrun = 1'b0;
    if ((fastIr || remote) && txUnderrunEvt) s_d.txUnderrun = 1'b1;
    if (wrAux && regWrData[AUX_CLEAR_TIMER]) s_d.clearTimer = 1'b1;

    // soft resets take priority: they model a reset, not a software clear
    if (txSr) begin
      s_d.setEot = 1'b0;
      s_d.txUnderrun = 1'b0;
    end
    if (rxSr) begin
      s_d.rxTimeout = 1'b0;
      s_d.rxActivity = 1'b0;
      s_d.rxSampling = 1'b0;
      s_d.frameTooLong = 1'b0;
      s_d.frameEnd = 1'b0;
    end
    if (!isFastIr(s_d.mode) && !isRemote(s_d.mode)) s_d.txUnderrun = 1'b0;
    // transmitter stays stopped until software clears the halt causes
    s_d.txHalted = s_d.txHaltFend | s_d.txUnderrun;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.txReady <= RESET_TX_READY;
      s_q.txEmpty <= RESET_TX_EMPTY;
      s_q.divisor <= RESET_DIVISOR;
      s_q.mode <= MODE_UART;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign txFifoPush = s_q.txPush;
  assign txFifoData = s_q.txData;
  assign setEndOfTransmit = s_q.setEot;
  assign txHalted = s_q.txHalted;
  assign rxFifoPop = s_q.rxPop;
  assign rxSamplingActive = s_q.rxSampling;
  assign statusReadPulse = s_q.statusRead;
  assign txSoftReset = s_q.txSoftRst;
  assign rxSoftReset = s_q.rxSoftRst;
  assign clearTimerEvent = s_q.clearTimer;
  assign divisorValue = s_q.divisor;
  assign operatingMode = s_q.mode;
  assign extendedMode = s_q.ext1[EXT1_EXTENDED_SELECT];
  assign modeControl = s_q.modeCtrl;
  assign extCtrl1 = s_q.ext1;
  assign extCtrl2 = s_q.ext2;
  assign irCtrl1 = s_q.ir1;
  assign irCtrl2 = s_q.ir2;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence legacyExtSeq;
    legacyAcc && ext;
  endsequence

  sequence fallbackDoneSeq;
    !s_q.ext1[EXT1_EXTENDED_SELECT] && (s_q.modeCtrl & FALLBACK_MCR_CLEAR) == 8'h00 &&
    (s_q.ext2 & FALLBACK_EXT2_CLEAR) == 8'h00 && s_q.mode == MODE_UART;
  endsequence

  sequence lockedWriteSeq;
    regWrEn && legacyAcc && !ext && s_q.ext2[EXT2_LOCK];
  endsequence

  a_tx_ready_drop: assert property (s_q.txPush |-> !s_q.txReady && !s_q.txEmpty)
    else $error("transmit ready still high after push");
  a_tx_empty_cause: assert property (s_q.txEmpty |-> $past(txHoldEmpty && txFrontIdle))
    else $error("transmitter empty without idle front end");
  a_fallback_clears: assert property (legacyExtSeq |=> fallbackDoneSeq ##0
                                      (s_q.rxSoftRst || $past(s_q.mode) == MODE_UART))
    else $error("legacy divisor access did not fall back");
  a_lock_holds_divisor: assert property (lockedWriteSeq |=> $stable(s_q.divisor))
    else $error("locked legacy write changed divisor");
  a_tx_soft_clear: assert property (s_q.txSoftRst |-> !s_q.setEot && !s_q.txUnderrun)
    else $error("transmit soft reset left aux bits");
  a_rx_soft_clear: assert property (s_q.rxSoftRst |-> !s_q.rxTimeout && !s_q.rxSampling)
    else $error("receive soft reset left aux bits");
  a_underrun_forced: assert property (!isFastIr(s_q.mode) && !isRemote(s_q.mode) |-> !s_q.txUnderrun)
    else $error("underrun set outside infrared modes");
  a_mode_change_reset: assert property (s_q.mode != $past(s_q.mode) |-> s_q.txSoftRst && s_q.rxSoftRst)
    else $error("mode change without soft resets");
  a_timer_clear_pulse: assert property (wrAux && regWrData[AUX_CLEAR_TIMER] |=> clearTimerEvent ##1
                                        (!clearTimerEvent || $past(wrAux && regWrData[AUX_CLEAR_TIMER])))
    else $error("clear timer event not a single pulse");
  a_status_read_clear: assert property (regRdEn && bank == BANK_0 && regAddr == OFS_LINK_STATUS && !frameEndEvt |=> !s_q.frameEnd)
    else $error("frame end survived status read");
  a_timeout_set_wins: assert property (rxTimeoutEvt && !rxSr |=> s_q.rxTimeout)
    else $error("receive timeout lost");
  a_eot_cleared_push: assert property (s_q.txPush && !$past(wrAux) |-> !s_q.setEot)
    else $error("end of transmit not cleared by push");
endmodule

// File: lsa_line_model.sv
`timescale 1ns/1ps
module lsa_line_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // transmit side
  input wire logic txFifoPush,
  output logic txHoldEmpty,
  output logic txFrontIdle
);
  logic [2:0] holdCnt_q;
  logic [3:0] frontCnt_q;
  // a pushed byte waits in the holding stage, the shifter stays busy twice as long
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt_q <= 3'h0;
      frontCnt_q <= 4'h0;
    end else if (txFifoPush) begin
      holdCnt_q <= 3'h4;
      frontCnt_q <= 4'h8;
    end else begin
      if (holdCnt_q != 3'h0) holdCnt_q <= holdCnt_q - 3'h1;
      if (frontCnt_q != 4'h0) frontCnt_q <= frontCnt_q - 4'h1;
    end
  end
  assign txHoldEmpty = (holdCnt_q == 3'h0);
  assign txFrontIdle = (frontCnt_q == 4'h0);
endmodule

// File: link_status_aux_and_divisor_fallback_bench.sv
`timescale 1ns/1ps
module link_status_aux_and_divisor_fallback_bench;
  import lsa_pkg::*;
  logic clock, rst_n, regWrEn, regRdEn, txHoldEmpty, txFrontIdle, txFifoPush, setEndOfTransmit;
  logic txHalted, fifoEnabled, errCharInFifo, eofInFifo, lostFrameBottom, rxFrameBusy;
  logic rxFifoPop, rxSamplingActive, statusReadPulse, txSoftReset, rxSoftReset, clearTimerEvent;
  logic txUnderrunEvt, txFrameCountZero, frameTooLongEvt, frameEndEvt, rxTimeoutEvt, irPulseEvt;
  logic txSoftResetReq, rxSoftResetReq, extendedMode;
  logic [2:0] regAddr, operatingMode;
  logic [4:0] rxLowStatus;
  logic [7:0] regWrData, regRdData, txFifoData, rxFifoData, txFifoLevel, rxFifoLevel, evt;
  logic [7:0] modeControl, extCtrl1, extCtrl2, irCtrl1, irCtrl2, rdv, pls;
  logic [15:0] divisorValue;
  int fails = 0;
  int nCompared = 0;

  assign {txUnderrunEvt, txFrameCountZero, frameTooLongEvt, frameEndEvt} = evt[7:4];
  assign {rxTimeoutEvt, irPulseEvt, txSoftResetReq, rxSoftResetReq} = evt[3:0];

  lsa_link_status_aux dut_u (.clock, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .txHoldEmpty, .txFrontIdle, .txUnderrunEvt, .txFrameCountZero, .txFifoPush,
    .txFifoData, .setEndOfTransmit, .txHalted, .rxFifoData, .rxLowStatus, .fifoEnabled,
    .errCharInFifo, .frameTooLongEvt, .frameEndEvt, .rxTimeoutEvt, .eofInFifo,
    .lostFrameBottom, .rxFrameBusy, .irPulseEvt, .rxFifoPop, .rxSamplingActive,
    .statusReadPulse, .txFifoLevel, .rxFifoLevel, .txSoftResetReq, .rxSoftResetReq,
    .txSoftReset, .rxSoftReset, .clearTimerEvent, .divisorValue, .operatingMode,
    .extendedMode, .modeControl, .extCtrl1, .extCtrl2, .irCtrl1, .irCtrl2);

  lsa_line_model line_u (.clock, .rst_n, .txFifoPush, .txHoldEmpty, .txFrontIdle);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pulses land in the first cycle after the strobe; both cycles after it are collected
  task automatic grab;
    #1 pls = pls | {2'h0, txFifoPush, rxFifoPop, statusReadPulse, clearTimerEvent,
                    txSoftReset, rxSoftReset};
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    pls = 8'h00;
    @(posedge clock);
    regWrEn <= 1'b0;
    grab();
    @(posedge clock);
    grab();
  endtask

  task automatic rd(input logic [2:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    pls = 8'h00;
    @(posedge clock);
    regRdEn <= 1'b0;
    grab();
    rdv = regRdData;
    @(posedge clock);
    grab();
  endtask

  task automatic sel(input logic [1:0] b);
    wr(OFS_LINK_CTRL, {b, 6'h00});
  endtask

  task automatic fire(input logic [7:0] m);
    evt <= m;
    @(posedge clock);
    evt <= 8'h00;
    @(posedge clock);
  endtask

  task automatic testTxStatus;
    rd(OFS_LINK_STATUS);
    chk(rdv, 8'h60);
    wr(OFS_DATA, 8'ha5);
    chk(pls, 8'h20);
    chk(txFifoData, 8'ha5);
    rd(OFS_LINK_STATUS);
    chk(rdv, 8'h00);
    repeat (4) @(posedge clock);
    rd(OFS_LINK_STATUS);
    chk(rdv, 8'h20);
    repeat (2) @(posedge clock);
    fifoEnabled <= 1'b1;
    errCharInFifo <= 1'b1;
    rd(OFS_LINK_STATUS);
    chk(rdv, 8'he0);
    fifoEnabled <= 1'b0;
    rd(OFS_LINK_STATUS);
    chk(rdv, 8'h60);
    errCharInFifo <= 1'b0;
    $display("transmit status test done");
  endtask

  task automatic testScratch;
    wr(OFS_SCRATCH_AUX, 8'h5a);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h5a);
    sel(BANK_2);
    wr(OFS_EXT_CTRL1, 8'h01);
    chk({7'h0, extendedMode}, 8'h01);
    sel(BANK_0);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h00);
    wr(OFS_SCRATCH_AUX, 8'h80);
    chk(pls, 8'h04);
    wr(OFS_SCRATCH_AUX, 8'h00);
    chk(pls, 8'h00);
    $display("scratchpad test done");
  endtask

  task automatic testFastIr;
    logic [2:0] codes [3] = '{MODE_CONSUMER_REMOTE, MODE_MEDIUM_IR, MODE_FAST_IR};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MODE_CTRL, {codes[i], 5'h00});
      chk(pls, 8'h03);
      chk({5'h0, operatingMode}, {5'h0, codes[i]});
    end
    fire(8'h08);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h01);
    rd(OFS_DATA);
    chk(rdv, 8'hc3);
    chk(pls, 8'h10);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h00);
    {eofInFifo, lostFrameBottom, rxFrameBusy} <= 3'h7;
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h32);
    {eofInFifo, lostFrameBottom, rxFrameBusy} <= 3'h0;
    fire(8'h80);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h40);
    chk({7'h0, txHalted}, 8'h01);
    wr(OFS_SCRATCH_AUX, 8'h40);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h00);
    wr(OFS_SCRATCH_AUX, 8'h04);
    chk({7'h0, setEndOfTransmit}, 8'h01);
    wr(OFS_DATA, 8'h11);
    chk({7'h0, setEndOfTransmit}, 8'h00);
    wr(OFS_SCRATCH_AUX, 8'h04);
    fire(8'h80);
    fire(8'h08);
    fire(8'h02);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h01);
    fire(8'h01);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h00);
    fire(8'h30);
    rd(OFS_LINK_STATUS);
    chk(rdv & 8'h90, 8'h90);
    chk(pls, 8'h08);
    rd(OFS_LINK_STATUS);
    chk(rdv & 8'h90, 8'h00);
    sel(BANK_3);
    wr(OFS_IR_CTRL2, 8'h02);
    chk(irCtrl2, 8'h02);
    sel(BANK_0);
    fire(8'h40);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h08);
    wr(OFS_SCRATCH_AUX, 8'h08);
    chk({7'h0, txHalted}, 8'h00);
    $display("fast infrared test done");
  endtask

  task automatic testRemote;
    wr(OFS_MODE_CTRL, {MODE_CONSUMER_REMOTE, 5'h00});
    fire(8'h04);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h30);
    chk({7'h0, rxSamplingActive}, 8'h01);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h20);
    wr(OFS_SCRATCH_AUX, 8'h20);
    chk({7'h0, rxSamplingActive}, 8'h00);
    fire(8'h80);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h40);
    wr(OFS_MODE_CTRL, 8'h00);
    fire(8'h80);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h00);
    $display("remote mode test done");
  endtask

  task automatic testFallback;
    sel(BANK_2);
    wr(OFS_EXT_CTRL2, 8'h3f);
    wr(OFS_EXT_CTRL1, 8'ha1);
    sel(BANK_3);
    wr(OFS_IR_CTRL1, 8'h0c);
    sel(BANK_0);
    wr(OFS_MODE_CTRL, 8'h9c);
    sel(BANK_1);
    rd(OFS_DIV_LOW);
    chk({extendedMode, operatingMode, 4'h0}, 8'h00);
    chk(modeControl | extCtrl1 | extCtrl2 | irCtrl1, 8'h00);
    rd(OFS_LINK_CTRL);
    chk(rdv, 8'h40);
    rd(3'h2);
    chk(rdv, 8'h00);
    sel(BANK_2);
    wr(OFS_EXT_CTRL1, 8'ha0);
    wr(OFS_EXT_CTRL2, 8'h3f);
    sel(BANK_1);
    wr(OFS_DIV_HIGH, 8'h12);
    chk(divisorValue[15:8], 8'h12);
    chk(extCtrl1 | extCtrl2, 8'h00);
    sel(BANK_2);
    wr(OFS_EXT_CTRL1, 8'ha0);
    wr(OFS_EXT_CTRL2, 8'h80);
    rd(OFS_TX_LEVEL);
    chk(rdv, 8'h07);
    sel(BANK_1);
    wr(OFS_DIV_LOW, 8'h34);
    chk(divisorValue[7:0], 8'h00);
    chk(extCtrl1, 8'ha0);
    sel(BANK_0);
    rd(OFS_SCRATCH_AUX);
    chk(rdv, 8'h5a);
    $display("divisor fallback test done");
  endtask

  initial begin
    rst_n = 1'b0;
    {regWrEn, regRdEn, fifoEnabled, errCharInFifo} = 4'h0;
    {eofInFifo, lostFrameBottom, rxFrameBusy} = 3'h0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    evt = 8'h00;
    rxFifoData = 8'hc3;
    rxLowStatus = 5'h00;
    txFifoLevel = 8'h07;
    rxFifoLevel = 8'h03;
    pls = 8'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    testTxStatus();
    testScratch();
    testFastIr();
    testRemote();
    testFallback();
    finish_test();
  end

  // hang guard, far beyond the length of the sequence above
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
endmodule
